// file: rtl/rps_pkg.sv
package rps_pkg;
	localparam int N_IN = 33;
	localparam int N_GRP = 4;
	localparam int N_SLOT = 16;
	localparam int N_OPIN = 64;
	localparam int N_PO = 28;
	localparam int ADDR_W = 12;
	localparam int IDX_UART5_CTS = 5;
	localparam int IDX_SPI4_DATA_IN = 7;
	localparam int IDX_CAN_RX = 16;
	// Byte offsets
	localparam logic [11:0] ISEL_BASE = 12'h000;
	localparam logic [11:0] OSEL_BASE = 12'h100;
	localparam logic [11:0] CTRL_OFS = 12'h200;
	localparam logic [11:0] KEY_OFS = 12'h204;
	// Control word fields
	localparam int UNLOCKED_BIT = 0;
	localparam int LOCK_BIT = 13;
	localparam int FUSE_BIT = 29;
	// Reset values
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic FUSE_DEFAULT = 1'b1;
	localparam logic [1:0] FUSE_SETTLE = 2'h3;
	// Unlock keys, arbitrary values
	localparam logic [31:0] KEY_FIRST = 32'h0000_5A5A;
	localparam logic [31:0] KEY_SECOND = 32'h0000_A5A5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Valid input codes per group, bit n for code n
	localparam logic [3:0][15:0] IN_CODE_OK =
		{16'h3BFF, 16'hFEFF, 16'hFFFF, 16'hBDFF};
	localparam logic [3:0][15:0] IN_NOT_64 =
		{16'h3200, 16'h7E00, 16'h3E00, 16'h3C00};
	localparam logic [3:0][15:0] IN_NOT_64USB =
		{16'h0800, 16'h0000, 16'h4000, 16'h8000};
	localparam logic [3:0][15:0] IN_ONLY_100GP =
		{16'h0000, 16'h0000, 16'h8000, 16'h0000};
	localparam logic [3:0][4:0] OPIN_CNT = {5'h0D, 5'h0E, 5'h0E, 5'h0D};
	// Peripheral output numbers
	localparam logic [4:0] PO_UART3_TX = 5'h00;
	localparam logic [4:0] PO_UART4_RTS = 5'h01;
	localparam logic [4:0] PO_SPI2_DATA_OUT = 5'h02;
	localparam logic [4:0] PO_COMPARE3 = 5'h03;
	localparam logic [4:0] PO_CAN_TX = 5'h04;
	localparam logic [4:0] PO_COMPARATOR2 = 5'h05;
	localparam logic [4:0] PO_SPI3_DATA_OUT = 5'h06;
	localparam logic [4:0] PO_SPI4_DATA_OUT = 5'h07;
	localparam logic [4:0] PO_UART2_TX = 5'h08;
	localparam logic [4:0] PO_UART1_TX = 5'h09;
	localparam logic [4:0] PO_UART5_RTS = 5'h0A;
	localparam logic [4:0] PO_SPI1_DATA_OUT = 5'h0B;
	localparam logic [4:0] PO_COMPARE4 = 5'h0C;
	localparam logic [4:0] PO_COMPARATOR3 = 5'h0D;
	localparam logic [4:0] PO_UART3_RTS = 5'h0E;
	localparam logic [4:0] PO_UART4_TX = 5'h0F;
	localparam logic [4:0] PO_REF_CLOCK_OUT = 5'h10;
	localparam logic [4:0] PO_UART5_TX = 5'h11;
	localparam logic [4:0] PO_SPI1_SELECT = 5'h12;
	localparam logic [4:0] PO_COMPARE5 = 5'h13;
	localparam logic [4:0] PO_COMPARATOR1 = 5'h14;
	localparam logic [4:0] PO_SPI3_SELECT = 5'h15;
	localparam logic [4:0] PO_SPI4_SELECT = 5'h16;
	localparam logic [4:0] PO_UART2_RTS = 5'h17;
	localparam logic [4:0] PO_UART1_RTS = 5'h18;
	localparam logic [4:0] PO_SPI2_SELECT = 5'h19;
	localparam logic [4:0] PO_COMPARE2 = 5'h1A;
	localparam logic [4:0] PO_COMPARE1 = 5'h1B;
	localparam logic [4:0] PO_NONE = 5'h1F;

	function automatic logic [4:0] out_map(input logic [1:0] grp,
		input logic [3:0] code);
		case ({grp, code})
			6'h01: out_map = PO_UART3_TX;
			6'h02: out_map = PO_UART4_RTS;
			6'h06: out_map = PO_SPI2_DATA_OUT;
			6'h0B: out_map = PO_COMPARE3;
			6'h0C: out_map = PO_CAN_TX;
			6'h0D: out_map = PO_COMPARATOR2;
			6'h0E: out_map = PO_SPI3_DATA_OUT;
			6'h0F: out_map = PO_SPI4_DATA_OUT;
			6'h11: out_map = PO_UART2_TX;
			6'h13: out_map = PO_UART1_TX;
			6'h14: out_map = PO_UART5_RTS;
			6'h16: out_map = PO_SPI2_DATA_OUT;
			6'h18: out_map = PO_SPI1_DATA_OUT;
			6'h1B: out_map = PO_COMPARE4;
			6'h1D: out_map = PO_COMPARATOR3;
			6'h1E: out_map = PO_SPI3_DATA_OUT;
			6'h1F: out_map = PO_SPI4_DATA_OUT;
			6'h21: out_map = PO_UART3_RTS;
			6'h22: out_map = PO_UART4_TX;
			6'h23: out_map = PO_REF_CLOCK_OUT;
			6'h24: out_map = PO_UART5_TX;
			6'h27: out_map = PO_SPI1_SELECT;
			6'h28: out_map = PO_SPI1_DATA_OUT;
			6'h2B: out_map = PO_COMPARE5;
			6'h2D: out_map = PO_COMPARATOR1;
			6'h2E: out_map = PO_SPI3_SELECT;
			6'h2F: out_map = PO_SPI4_SELECT;
			6'h31: out_map = PO_UART2_RTS;
			6'h33: out_map = PO_UART1_RTS;
			6'h34: out_map = PO_UART5_TX;
			6'h36: out_map = PO_SPI2_SELECT;
			6'h38: out_map = PO_SPI1_DATA_OUT;
			6'h3B: out_map = PO_COMPARE2;
			6'h3C: out_map = PO_COMPARE1;
			default: out_map = PO_NONE;
		endcase
	endfunction

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} rps_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rps_axi_rsp_t;

	typedef struct packed {
		logic [N_IN-1:0][3:0] isel;
		logic [N_OPIN-1:0][3:0] osel;
		logic lock;
		logic fuse;
		logic [1:0] fuse_wait;
		logic fuse_s1;
		logic fuse_s2;
		logic unlocked;
		logic key_stage;
		logic [N_GRP-1:0][N_SLOT-1:0] pin_s1;
		logic [N_GRP-1:0][N_SLOT-1:0] pin_s2;
		logic [N_IN-1:0] periph_in;
		logic [N_OPIN-1:0] pin_out;
		logic [N_OPIN-1:0] pin_oe;
		logic [N_OPIN-1:0] remap;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		rps_axi_rsp_t rsp;
	} rps_state_t;
endpackage

// file: rtl/rps_top.sv
`timescale 1ns/100ps
// Contract
// - Separate select sets for peripheral inputs and for peripheral outputs.
// - Each peripheral input has a 4-bit field choosing its source pin.
// - Input group one: fourteen pins by code, codes 1001 and 1110 reserved.
// - Input group two: all sixteen codes select pins, none reserved.
// - Input group three: codes select pins, code 1000 reserved.
// - Input group four: codes 1010, 1110 and 1111 reserved.
// - Each remappable pin has a 4-bit field choosing its peripheral output.
// - Output code 0000 is no connection and is the reset value.
// - Output group one code table.
// - Output group two code table.
// - Output group three code table.
// - Output group four code table.
// - While locked, select writes complete normally but change nothing.
// - Lock bit changes only after the unlock key sequence.
// - With fuse set, a set lock cannot clear until reset.
// - Fuse reads as set by default: one mapping session per reset.
// - Codes for pins or peripherals absent on a variant are unavailable.
// - Remapped output beats other digital functions, never analog ones.
// - Remappable peripherals reach no pin until software maps them; inputs reset to code 0000, which selects a pin in every group.
module rps_top #(
	parameter int PKG_100PIN = 1,
	parameter int USB_DEVICE = 0,
	parameter int HAS_CAN = 1,
	parameter logic [32:0] INPUT_IDLE = 33'h0
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// Register bus
	input wire rps_pkg::rps_axi_req_t AXI_REQ,
	output rps_pkg::rps_axi_rsp_t AXI_RSP,
	// Boot configuration strap
	input wire logic SINGLE_SESSION_LOCK_FUSE,
	// Remappable pins
	input wire logic [rps_pkg::N_GRP-1:0][rps_pkg::N_SLOT-1:0] PIN_IN,
	output logic [rps_pkg::N_OPIN-1:0] PIN_OUT,
	output logic [rps_pkg::N_OPIN-1:0] PIN_OE,
	output logic [rps_pkg::N_OPIN-1:0] PIN_REMAP_ACTIVE,
	// Port logic
	input wire logic [rps_pkg::N_OPIN-1:0] PORT_OUT_DATA,
	input wire logic [rps_pkg::N_OPIN-1:0] PORT_OUT_OE,
	input wire logic [rps_pkg::N_OPIN-1:0] ANALOG_SEL,
	// Peripherals
	input wire logic [rps_pkg::N_PO-1:0] PERIPH_OUT_DATA,
	input wire logic [rps_pkg::N_PO-1:0] PERIPH_OUT_OE,
	output logic [rps_pkg::N_IN-1:0] PERIPH_IN_DATA,
	output logic MAPPING_WRITE_LOCK
);
	import rps_pkg::*;

	localparam logic [9:0] W_ISEL = ISEL_BASE[11:2];
	localparam logic [9:0] W_OSEL = OSEL_BASE[11:2];
	localparam logic [9:0] W_CTRL = CTRL_OFS[11:2];
	localparam logic [9:0] W_KEY = KEY_OFS[11:2];
	localparam logic [9:0] W_ISEL_END = W_ISEL + 10'(N_IN);
	localparam logic [9:0] W_OSEL_END = W_OSEL + 10'(N_OPIN);
	localparam logic [1:0] K_ISEL = 2'h0;
	localparam logic [1:0] K_OSEL = 2'h1;
	localparam logic [1:0] K_CTRL = 2'h2;
	localparam logic [1:0] K_KEY = 2'h3;

	rps_state_t s;
	rps_state_t next_s;
	logic [N_GRP-1:0][15:0] in_avail;
	logic [31:0] po_avail;
	logic [N_IN-1:0] in_present;
	logic [31:0] po_data;
	logic [31:0] po_oe;
	logic wr_fire;

	generate
		if (PKG_100PIN > 1 || PKG_100PIN < 0 || USB_DEVICE > 1
			|| USB_DEVICE < 0 || HAS_CAN > 1 || HAS_CAN < 0) begin : g_bad
			$error("rps_top: variant parameters must be 0 or 1");
		end
		for (genvar g = 0; g < N_GRP; g++) begin : g_avail
			// Codes whose pins are missing on this variant
			assign in_avail[g] = IN_CODE_OK[g]
				& ~((PKG_100PIN == 0) ? IN_NOT_64[g] : 16'h0)
				& ~((PKG_100PIN == 0 && USB_DEVICE == 1)
					? IN_NOT_64USB[g] : 16'h0)
				& ~((PKG_100PIN == 1 && USB_DEVICE == 0)
					? 16'h0 : IN_ONLY_100GP[g]);
		end
	endgenerate

	always_comb begin
		po_avail = 32'h0FFF_FFFF;
		if (PKG_100PIN == 0) begin
			po_avail[PO_SPI4_DATA_OUT] = 1'b0;
			po_avail[PO_UART5_RTS] = 1'b0;
			po_avail[PO_UART5_TX] = 1'b0;
			po_avail[PO_SPI4_SELECT] = 1'b0;
		end
		if (HAS_CAN == 0) begin
			po_avail[PO_CAN_TX] = 1'b0;
		end
		in_present = {N_IN{1'b1}};
		if (PKG_100PIN == 0) begin
			in_present[IDX_UART5_CTS] = 1'b0;
			in_present[IDX_SPI4_DATA_IN] = 1'b0;
		end
		if (HAS_CAN == 0) begin
			in_present[IDX_CAN_RX] = 1'b0;
		end
	end

	assign po_data = {4'h0, PERIPH_OUT_DATA};
	assign po_oe = {4'h0, PERIPH_OUT_OE};
	assign wr_fire = s.aw_have && s.w_have;

	// Returns {mapped, kind}
	function automatic logic [2:0] reg_kind(input logic [9:0] w);
		logic [5:0] slot;
		slot = 6'(w - W_OSEL);
		if (w >= W_ISEL && w < W_ISEL_END) begin
			reg_kind = {1'b1, K_ISEL};
		end else if (w >= W_OSEL && w < W_OSEL_END) begin
			reg_kind = {5'({1'b0, slot[3:0]}) < OPIN_CNT[slot[5:4]],
				K_OSEL};
		end else if (w == W_CTRL) begin
			reg_kind = {1'b1, K_CTRL};
		end else if (w == W_KEY) begin
			reg_kind = {1'b1, K_KEY};
		end else begin
			reg_kind = 3'h0;
		end
	endfunction

	always_comb begin
		logic [9:0] w;
		logic [2:0] kind;
		logic [5:0] idx;
		logic [1:0] g;
		logic [3:0] c;
		logic [4:0] po;
		logic ok;
		w = 10'h0;
		kind = 3'h0;
		idx = 6'h0;
		g = 2'h0;
		c = 4'h0;
		po = PO_NONE;
		ok = 1'b0;
		next_s = s;
		next_s.pin_s1 = PIN_IN;
		next_s.pin_s2 = s.pin_s1;
		next_s.fuse_s1 = SINGLE_SESSION_LOCK_FUSE;
		next_s.fuse_s2 = s.fuse_s1;
		// Fuse held set until the strap has crossed the synchroniser
		if (s.fuse_wait != FUSE_SETTLE) begin
			next_s.fuse_wait = s.fuse_wait + 2'h1;
			if (s.fuse_wait == FUSE_SETTLE - 2'h1) begin
				next_s.fuse = s.fuse_s2;
			end
		end

		// Write channel: address and data in either order
		if (AXI_REQ.awvalid && s.rsp.awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr = AXI_REQ.awaddr;
		end
		if (AXI_REQ.wvalid && s.rsp.wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata = AXI_REQ.wdata;
			next_s.wstrb = AXI_REQ.wstrb;
		end
		if (s.rsp.bvalid && AXI_REQ.bready) begin
			next_s.rsp.bvalid = 1'b0;
		end
		if (wr_fire) begin
			w = s.awaddr[11:2];
			kind = reg_kind(w);
			idx = w[5:0];
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp = kind[2] ? RESP_OKAY : RESP_SLVERR;
			if (kind[2]) begin
				case (kind[1:0])
					K_ISEL: begin
						if (!s.lock && s.wstrb[0]) begin
							next_s.isel[idx] = s.wdata[3:0];
						end
					end
					K_OSEL: begin
						if (!s.lock && s.wstrb[0]) begin
							next_s.osel[idx] = s.wdata[3:0];
						end
					end
					K_CTRL: begin
						// One lock change per unlock sequence
						if (s.unlocked && s.wstrb[1]) begin
							if (s.wdata[LOCK_BIT]) begin
								next_s.lock = 1'b1;
							end else if (!s.fuse) begin
								next_s.lock = 1'b0;
							end
							next_s.unlocked = 1'b0;
						end
					end
					default: begin
						next_s.key_stage = 1'b0;
						if (s.wstrb == 4'hF) begin
							if (s.wdata == KEY_FIRST) begin
								next_s.key_stage = 1'b1;
							end else if (s.key_stage
								&& s.wdata == KEY_SECOND) begin
								next_s.unlocked = 1'b1;
							end
						end
					end
				endcase
			end
		end
		next_s.rsp.awready = !next_s.aw_have && !next_s.rsp.bvalid;
		next_s.rsp.wready = !next_s.w_have && !next_s.rsp.bvalid;

		// Read channel
		if (s.rsp.rvalid && AXI_REQ.rready) begin
			next_s.rsp.rvalid = 1'b0;
		end
		if (AXI_REQ.arvalid && s.rsp.arready) begin
			w = AXI_REQ.araddr[11:2];
			kind = reg_kind(w);
			idx = w[5:0];
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rresp = kind[2] ? RESP_OKAY : RESP_SLVERR;
			next_s.rsp.rdata = 32'h0;
			if (kind[2]) begin
				case (kind[1:0])
					K_ISEL: next_s.rsp.rdata[3:0] = s.isel[idx];
					K_OSEL: next_s.rsp.rdata[3:0] = s.osel[idx];
					K_CTRL: begin
						next_s.rsp.rdata[LOCK_BIT] = s.lock;
						next_s.rsp.rdata[FUSE_BIT] = s.fuse;
						next_s.rsp.rdata[UNLOCKED_BIT] = s.unlocked;
					end
					default: next_s.rsp.rdata = 32'h0;
				endcase
			end
		end
		next_s.rsp.arready = !next_s.rsp.rvalid;

		// Input routing, one field per peripheral input
		for (int i = 0; i < N_IN; i++) begin
			g = (i < 9) ? 2'h0 : (i < 17) ? 2'h1 : (i < 25) ? 2'h2 : 2'h3;
			c = s.isel[i];
			ok = in_avail[g][c] && in_present[i];
			next_s.periph_in[i] = ok ? s.pin_s2[g][c] : INPUT_IDLE[i];
		end

		// Output routing, one field per pin
		for (int k = 0; k < N_OPIN; k++) begin
			g = 2'(k / N_SLOT);
			po = out_map(g, s.osel[k]);
			// Analog use of the pin always wins
			ok = (po != PO_NONE) && po_avail[po] && !ANALOG_SEL[k];
			next_s.remap[k] = ok;
			next_s.pin_out[k] = ok ? po_data[po] : PORT_OUT_DATA[k];
			next_s.pin_oe[k] = ok ? po_oe[po] : PORT_OUT_OE[k];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			s <= '0;
			s.isel <= {N_IN{SEL_RESET}};
			s.osel <= {N_OPIN{SEL_RESET}};
			s.lock <= LOCK_RESET;
			s.fuse <= FUSE_DEFAULT;
			s.fuse_s1 <= FUSE_DEFAULT;
			s.fuse_s2 <= FUSE_DEFAULT;
		end else begin
			s <= next_s;
		end
	end

	assign AXI_RSP = s.rsp;
	assign PIN_OUT = s.pin_out;
	assign PIN_OE = s.pin_oe;
	assign PIN_REMAP_ACTIVE = s.remap;
	assign PERIPH_IN_DATA = s.periph_in;
	assign MAPPING_WRITE_LOCK = s.lock;

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);

	AST_LOCKED_NO_CHANGE: assert property (
		(wr_fire && s.lock) |=> ($stable(s.isel) && $stable(s.osel)))
		else $error("select changed while locked");
	AST_LOCKED_OKAY: assert property (
		(wr_fire && s.lock && s.awaddr[11:2] < W_ISEL_END)
		|=> (s.rsp.bvalid && s.rsp.bresp == RESP_OKAY))
		else $error("locked write not answered okay");
	AST_FUSE_HOLDS: assert property (
		(s.lock && s.fuse) |=> s.lock)
		else $error("lock cleared with fuse set");
	AST_LOCK_KEYED: assert property (
		(!s.lock ##1 s.lock) |-> $past(s.unlocked))
		else $error("lock set without unlock sequence");
	AST_FUSE_AFTER_RESET: assert property (
		$rose(RESET_N) |-> (s.fuse ##1 s.fuse))
		else $error("fuse not set after reset");
	AST_NC_NO_DRIVE: assert property (
		(s.osel == '0) |=> (s.remap == '0))
		else $error("pin driven with no connection code");
	AST_ANALOG_WINS: assert property (
		1'b1 |=> ((s.remap & $past(ANALOG_SEL)) == '0))
		else $error("remap active on analog pin");
	AST_RESERVED_IDLE: assert property (
		(s.isel[0] == 4'h9) |=> (s.periph_in[0] == INPUT_IDLE[0]))
		else $error("reserved input code not idle");
	AST_INPUT_ROUTE: assert property (
		(s.isel[3] == 4'h5) |=> (s.periph_in[3] == $past(s.pin_s2[0][5])))
		else $error("input not routed from selected pin");
	AST_OUTPUT_WRITE: assert property (
		(wr_fire && !s.lock && s.wstrb[0] && s.awaddr == OSEL_BASE)
		|=> (s.osel[0] == $past(s.wdata[3:0])))
		else $error("unlocked output select write lost");
	AST_RESET_SELECTS: assert property (
		$rose(RESET_N) |-> (s.isel == '0 && s.osel == '0))
		else $error("selects not cleared by reset");
	AST_RESET_UNLOCKED: assert property (
		$rose(RESET_N) |-> !s.lock)
		else $error("lock not cleared by reset");
	AST_NO_REMAP_AT_START: assert property (
		$rose(RESET_N) |-> ((s.remap == '0) ##1 (s.remap == '0)))
		else $error("pin remapped before any select write");
	AST_FUSE_SETTLING: assert property (
		(s.fuse_wait != FUSE_SETTLE) |-> s.fuse)
		else $error("fuse not held set while strap settles");
	AST_FUSE_STEADY: assert property (
		(s.fuse_wait == FUSE_SETTLE) |=> $stable(s.fuse))
		else $error("fuse changed between resets");
	AST_LOCK_STEADY: assert property (
		!(wr_fire && s.unlocked) |=> $stable(s.lock))
		else $error("lock changed without unlock sequence");
	AST_UNLOCK_USED: assert property (
		(wr_fire && s.awaddr[11:2] == W_CTRL && s.wstrb[1])
		|=> !s.unlocked)
		else $error("unlock not consumed by control write");
	AST_FIRST_KEY: assert property (
		(wr_fire && s.awaddr[11:2] == W_KEY && s.wstrb == 4'hF
			&& s.wdata == KEY_FIRST) |=> s.key_stage)
		else $error("first key not recorded");
	AST_WRITE_ANSWERED: assert property (
		wr_fire |=> s.rsp.bvalid)
		else $error("write not answered");
	AST_INPUT_WRITE: assert property (
		(wr_fire && !s.lock && s.wstrb[0] && s.awaddr == ISEL_BASE)
		|=> (s.isel[0] == $past(s.wdata[3:0])))
		else $error("unlocked input select write lost");
	AST_RESERVED_OUT: assert property (
		(s.osel[2] == 4'h3) |=> !s.remap[2])
		else $error("reserved output code drives pin");
	AST_ANALOG_PORT: assert property (
		ANALOG_SEL[20] |=> (s.pin_out[20] == $past(PORT_OUT_DATA[20])))
		else $error("analog pin not left to port logic");
	AST_OUTPUT_ROUTE: assert property (
		(s.osel[0] == 4'h1 && !ANALOG_SEL[0])
		|=> (s.pin_out[0] == $past(po_data[PO_UART3_TX])))
		else $error("output not routed from selected peripheral");
	AST_GROUP_TWO_ROUTE: assert property (
		(s.isel[9] == 4'h0) |=> (s.periph_in[9] == $past(s.pin_s2[1][0])))
		else $error("group two input not routed");
	AST_GROUP_THREE_GAP: assert property (
		(s.isel[17] == 4'h8) |=> (s.periph_in[17] == INPUT_IDLE[17]))
		else $error("group three reserved code not idle");
	AST_GROUP_FOUR_GAP: assert property (
		(s.isel[25] == 4'hF) |=> (s.periph_in[25] == INPUT_IDLE[25]))
		else $error("group four reserved code not idle");
endmodule

// file: verification/rps_far_model.sv
`timescale 1ns/100ps
module rps_far_model
	import rps_pkg::*;
(
	// Clock and load strobe
	input wire logic clk,
	input wire logic load,
	// Next peripheral and pin levels
	input wire logic [rps_pkg::N_PO-1:0] new_data,
	input wire logic [rps_pkg::N_PO-1:0] new_oe,
	input wire logic [rps_pkg::N_GRP-1:0][rps_pkg::N_SLOT-1:0] new_pins,
	// Toward the block
	output logic [rps_pkg::N_PO-1:0] periph_data,
	output logic [rps_pkg::N_PO-1:0] periph_oe,
	output logic [rps_pkg::N_GRP-1:0][rps_pkg::N_SLOT-1:0] pins
);
	initial begin
		periph_data = '0;
		periph_oe = '0;
		pins = '0;
	end

	// Peripheral outputs and pin levels move only on a load
	always @(posedge clk) begin
		if (load) begin
			periph_data <= new_data;
			periph_oe <= new_oe;
			pins <= new_pins;
		end
	end
endmodule

// file: verification/test_remappable_pin_select.sv
`timescale 1ns/100ps
module test_remappable_pin_select;
	import rps_pkg::*;
	logic ref_clk;
	logic reset_n;
	rps_axi_req_t axi_req;
	rps_axi_rsp_t axi_rsp;
	logic fuse_strap;
	logic load;
	logic map_lock;
	logic [N_GRP-1:0][N_SLOT-1:0] pin_in, new_pins;
	logic [N_OPIN-1:0] pin_out, pin_oe, pin_remap, port_data, port_oe, analog;
	logic [N_PO-1:0] po_data, po_oe, new_po_data, new_po_oe;
	logic [N_IN-1:0] pi_data;
	logic [33:0] rd_q[$];
	logic [1:0] wr_q[$];
	logic [33:0] rd_exp;
	logic [1:0] wr_exp;
	int fail_count, total_checks, cycles;
	int opin[8] = '{0, 0, 16, 16, 32, 32, 48, 48};
	logic [3:0] ocode[8] = '{4'h1, 4'hC, 4'h3, 4'h8, 4'h3, 4'hD, 4'hC, 4'hB};
	logic [4:0] opo[8] = '{PO_UART3_TX, PO_CAN_TX, PO_UART1_TX,
		PO_SPI1_DATA_OUT, PO_REF_CLOCK_OUT, PO_COMPARATOR1, PO_COMPARE1,
		PO_COMPARE2};
	int ibase[4] = '{0, 9, 17, 25};
	int isz[4] = '{9, 8, 8, 8};

	rps_far_model far (.clk(ref_clk), .load(load), .new_data(new_po_data),
		.new_oe(new_po_oe), .new_pins(new_pins), .periph_data(po_data),
		.periph_oe(po_oe), .pins(pin_in));

	rps_top uut (.REF_CLK(ref_clk), .RESET_N(reset_n), .AXI_REQ(axi_req),
		.AXI_RSP(axi_rsp), .SINGLE_SESSION_LOCK_FUSE(fuse_strap),
		.PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PIN_REMAP_ACTIVE(pin_remap), .PORT_OUT_DATA(port_data),
		.PORT_OUT_OE(port_oe), .ANALOG_SEL(analog),
		.PERIPH_OUT_DATA(po_data), .PERIPH_OUT_OE(po_oe),
		.PERIPH_IN_DATA(pi_data), .MAPPING_WRITE_LOCK(map_lock));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t bus value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t pin level %b expected %b", $time, got, exp);
		end
	endtask

	// Bus answers are compared against the oldest note
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (axi_rsp.rvalid && axi_req.rready) begin
			rd_exp = rd_q.pop_front();
			check_word(axi_rsp.rdata, rd_exp[31:0]);
			check_word({30'h0, axi_rsp.rresp}, {30'h0, rd_exp[33:32]});
		end
		if (axi_rsp.bvalid && axi_req.bready) begin
			wr_exp = wr_q.pop_front();
			check_word({30'h0, axi_rsp.bresp}, {30'h0, wr_exp});
		end
		if (cycles == 20000) begin
			fail_count++;
			$display("[ERR] %0t run did not finish", $time);
			summarize();
		end
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		wr_q.push_back(er);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (axi_req.awvalid && axi_rsp.awready)
				axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready)
				axi_req.wvalid <= 1'b0;
		end while (!(axi_rsp.bvalid && axi_req.bready));
		axi_req.bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		rd_q.push_back({er, ed});
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		axi_req.rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (axi_req.arvalid && axi_rsp.arready)
				axi_req.arvalid <= 1'b0;
		end while (!(axi_rsp.rvalid && axi_req.rready));
		axi_req.rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic do_reset(input logic strap);
		fuse_strap <= strap;
		reset_n <= 1'b0;
		axi_req <= '0;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic unlock;
		wr(KEY_OFS, KEY_FIRST, RESP_OKAY);
		wr(KEY_OFS, KEY_SECOND, RESP_OKAY);
	endtask

	// New random levels on every peripheral and port, and on every pin unless fill drives all pins high
	task automatic shuffle(input logic fill);
		logic [63:0] r;
		r = {$urandom, $urandom};
		new_po_data <= r[N_PO-1:0];
		new_po_oe <= r[63:64-N_PO];
		new_pins <= fill ? '1 : {$urandom, $urandom};
		port_data <= {$urandom, $urandom};
		port_oe <= {$urandom, $urandom};
		load <= 1'b1;
		@(posedge ref_clk);
		load <= 1'b0;
		repeat (5) @(posedge ref_clk);
	endtask

	task automatic out_case(input int k, input logic [3:0] c,
		input logic [4:0] po);
		wr(OSEL_BASE + 12'(4 * k), {28'h0, c}, RESP_OKAY);
		rd(OSEL_BASE + 12'(4 * k), {28'h0, c}, RESP_OKAY);
		shuffle(1'b0);
		@(negedge ref_clk);
		check_bit(pin_remap[k], po != PO_NONE);
		check_bit(pin_out[k], po == PO_NONE ? port_data[k] : po_data[po]);
		check_bit(pin_oe[k], po == PO_NONE ? port_oe[k] : po_oe[po]);
		@(posedge ref_clk);
	endtask

	function automatic logic reserved(input int g, input logic [3:0] c);
		case (g)
			0: reserved = (c == 4'h9) || (c == 4'hE);
			2: reserved = (c == 4'h8);
			3: reserved = (c == 4'hA) || (c >= 4'hE);
			default: reserved = 1'b0;
		endcase
	endfunction

	task automatic in_case(input int i, input int g, input logic [3:0] c);
		logic ok;
		ok = !reserved(g, c);
		wr(ISEL_BASE + 12'(4 * i), {28'h0, c}, RESP_OKAY);
		shuffle(!ok);
		@(negedge ref_clk);
		check_bit(pi_data[i], ok ? pin_in[g][c] : 1'b0);
		@(posedge ref_clk);
	endtask

	initial begin
		axi_req = '0;
		reset_n = 1'b0;
		fuse_strap = 1'b1;
		load = 1'b0;
		new_po_data = '0;
		new_po_oe = '0;
		new_pins = '0;
		port_data = '0;
		port_oe = '0;
		analog = '0;
		fail_count = 0;
		total_checks = 0;
		cycles = 0;
		void'($urandom(27));
		do_reset(1'b1);
		check_bit(|pin_remap, 1'b0);
		check_bit(map_lock, 1'b0);
		rd(ISEL_BASE + 12'h014, 32'h0, RESP_OKAY);
		rd(OSEL_BASE + 12'h0F0, 32'h0, RESP_OKAY);
		rd(CTRL_OFS, 32'h2000_0000, RESP_OKAY);
		rd(12'hFFC, 32'h0, RESP_SLVERR);
		wr(12'hFFC, 32'hFFFF_FFFF, RESP_SLVERR);
		for (int n = 0; n < 8; n++) begin
			int k;
			k = opin[n] + int'($urandom % 13);
			out_case(k, ocode[n], opo[n]);
		end
		out_case(2, 4'h3, PO_NONE);
		out_case(50, 4'h0, PO_NONE);
		out_case(20, 4'h1, PO_UART2_TX);
		analog[20] <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		check_bit(pin_remap[20], 1'b0);
		@(posedge ref_clk);
		analog <= '0;
		for (int g = 0; g < 4; g++) begin
			for (int c = 0; c < 16; c++) begin
				int i;
				i = ibase[g] + int'($urandom % isz[g]);
				in_case(i, g, 4'(c));
			end
		end
		in_case(0, 0, 4'h9);
		in_case(3, 0, 4'h5);
		in_case(17, 2, 4'h8);
		in_case(25, 3, 4'hF);
		wr(OSEL_BASE, 32'h1, RESP_OKAY);
		wr(ISEL_BASE, 32'h2, RESP_OKAY);
		wr(CTRL_OFS, 32'h2000, RESP_OKAY);
		rd(CTRL_OFS, 32'h2000_0000, RESP_OKAY);
		unlock();
		rd(CTRL_OFS, 32'h2000_0001, RESP_OKAY);
		wr(CTRL_OFS, 32'h2000, RESP_OKAY);
		rd(CTRL_OFS, 32'h2000_2000, RESP_OKAY);
		check_bit(map_lock, 1'b1);
		wr(OSEL_BASE, 32'h6, RESP_OKAY);
		wr(ISEL_BASE, 32'h5, RESP_OKAY);
		rd(OSEL_BASE, 32'h1, RESP_OKAY);
		rd(ISEL_BASE, 32'h2, RESP_OKAY);
		unlock();
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		rd(CTRL_OFS, 32'h2000_2000, RESP_OKAY);
		do_reset(1'b0);
		rd(CTRL_OFS, 32'h0, RESP_OKAY);
		rd(ISEL_BASE, 32'h0, RESP_OKAY);
		unlock();
		wr(CTRL_OFS, 32'h2000, RESP_OKAY);
		unlock();
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		rd(CTRL_OFS, 32'h0, RESP_OKAY);
		wr(OSEL_BASE, 32'h6, RESP_OKAY);
		rd(OSEL_BASE, 32'h6, RESP_OKAY);
		repeat (4) @(posedge ref_clk);
		summarize();
	end
endmodule
